// >>> hdl/medc_defs.vh
/*
  Constants of the MAC energy-saving and duplex control block:
  register offsets, field positions, reset values and line codes.
  Assumes inclusion by bare name from the design files.
*/
`ifndef MEDC_DEFS_VH
`define MEDC_DEFS_VH

// ============================================================
// Register offsets (byte addresses)
`define MEDC_ADDR_W        12
`define MEDC_OFF_CONTROL   12'h100
`define MEDC_OFF_ENABLE    12'h104
`define MEDC_OFF_DELAY     12'h108
`define MEDC_OFF_STATUS    12'h10c

// ============================================================
// mac_control field positions
`define MEDC_CTL_HALT      18
`define MEDC_CTL_EEE       17
`define MEDC_CTL_SELFX     16
`define MEDC_CTL_POL       13
`define MEDC_CTL_AUTO      12
`define MEDC_CTL_DPX       3

// ============================================================
// mac_enable and status field positions
`define MEDC_EN_RX         0
`define MEDC_EN_TX         1
`define MEDC_ST_TX_LPI     0
`define MEDC_ST_RX_LPI     1
`define MEDC_ST_FULL       2
`define MEDC_ST_HALTED     3

// ============================================================
// Reset values
`define MEDC_RST_HALT      1'b0
`define MEDC_RST_EEE       1'b0
`define MEDC_RST_SELFX     1'b0
`define MEDC_RST_POL       1'b1
`define MEDC_RST_AUTO      1'b0
`define MEDC_RST_DPX       1'b0
`define MEDC_RST_DELAY     32'h0000_0000

// ============================================================
// Line codes and link speed code
`define MEDC_LPI_CODE      8'h01
`define MEDC_IDLE_CODE     8'h00
`define MEDC_SPEED_100     2'b01

`endif

// >>> hdl/medc_sync.v
/*
  Two-flop synchroniser for a bundle of independent levels.
  Assumes each bit is a slow level or a clock far slower than sys_clk_i.
*/
`timescale 1ns/100ps
module medc_sync #(
  parameter W = 1
) (
  input  wire         sys_clk_i,
  input  wire         sys_rst_i,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] stage1_q;
  reg [W-1:0] stage2_q;

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage1_q <= {W{1'b0}};
      stage2_q <= {W{1'b0}};
    end else begin
      stage1_q <= async_i;
      stage2_q <= stage1_q;
    end
  end

  assign sync_o = stage2_q;
endmodule // medc_sync

// >>> hdl/medc_lpi_timer.v
/*
  Down-counter timing the self-exit delay from the start of transmit LPI.
  Assumes start is a single-cycle pulse on sys_clk_i; clear may be held high as a level.
*/
`timescale 1ns/100ps
module medc_lpi_timer #(
  parameter W = 32
) (
  input  wire         sys_clk_i,
  input  wire         sys_rst_i,
  input  wire         clear_i,
  input  wire         start_i,
  input  wire [W-1:0] delay_i,
  output wire         expired_o
);
  reg [W-1:0] count_q;
  reg         run_q;
  reg         done_q;

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_q <= {W{1'b0}};
      run_q   <= 1'b0;
      done_q  <= 1'b0;
    end else if (clear_i) begin
      run_q   <= 1'b0;
      done_q  <= 1'b0;
    end else if (start_i) begin
      count_q <= delay_i;
      run_q   <= 1'b1;
      done_q  <= 1'b0;
    end else if (run_q) begin
      if (count_q == {W{1'b0}}) begin
        run_q  <= 1'b0;
        done_q <= 1'b1;
      end else begin
        count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign expired_o = done_q;
endmodule // medc_lpi_timer

// >>> hdl/medc_top.v
/*
  MAC control slice for energy-efficient Ethernet and duplex selection:
  APB register file, transmit LPI sequencing with self-exit, receive LPI
  decode, transmit clock halt and automatic duplex detection.
  Assumes an APB master on sys_clk_i, a PHY on GMII whose receive pins and
  duplex pin are asynchronous, and a forwarded transmit clock source that is
  slow enough to be sampled by sys_clk_i.
*/
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "medc_defs.vh"

// Function
// - Halt transmit clock during transmit LPI
// - Clock halt ignored at 100 Mbit/s
// - Energy-saving enable gates all LPI functions
// - LPI requests independent of transmitter enable
// - LPI decode independent of receiver enable
// - Self-exit drops transmit LPI after delay
// - Delay timed from LPI start, own register
// - Polarity bit chooses duplex pin sense
// - Auto detection overrides programmed duplex
// - Detected duplex written back to duplex_select
// - Protected fields survive lite reset
module medc_top #(
  parameter DELAY_W = 32
) (
  input  wire                     sys_clk_i,
  input  wire                     sys_rst_i,
  input  wire                     lite_rst_i,
  input  wire                     rst_protect_i,
  input  wire [`MEDC_ADDR_W-1:0]  paddr_i,
  input  wire                     psel_i,
  input  wire                     penable_i,
  input  wire                     pwrite_i,
  input  wire [31:0]              pwdata_i,
  output wire [31:0]              prdata_o,
  output wire                     pready_o,
  output wire                     pslverr_o,
  input  wire [1:0]               link_speed_i,
  input  wire                     tx_lpi_request_i,
  input  wire                     tx_clk_src_i,
  output wire                     gtx_clk_o,
  output wire                     gmii_tx_er_o,
  output wire [7:0]               gmii_txd_o,
  input  wire                     gmii_rx_dv_i,
  input  wire                     gmii_rx_er_i,
  input  wire [7:0]               gmii_rxd_i,
  input  wire                     phy_duplex_indication_i,
  output wire                     tx_lpi_active_o,
  output wire                     rx_lpi_active_o,
  output wire                     duplex_full_o,
  output wire                     transmitter_enable_o,
  output wire                     receiver_enable_o
);

  // ==========================================================
  // Transmit LPI states
  localparam [2:0] ST_ACTIVE = 3'b001;
  localparam [2:0] ST_LPI    = 3'b010;
  localparam [2:0] ST_EXITED = 3'b100;

  // ==========================================================
  // Declarations
  reg                tx_clock_halt_enable_q;
  reg                energy_saving_enable_q;
  reg                lpi_self_exit_enable_q;
  reg                duplex_indication_polarity_q;
  reg                auto_duplex_q;
  reg                duplex_select_q;
  reg                transmitter_enable_q;
  reg                receiver_enable_q;
  reg [DELAY_W-1:0]  lpi_self_exit_delay_q;
  reg [31:0]         prdata_q;
  reg                pready_q;
  reg                pslverr_q;
  reg [2:0]          tx_state_q;
  reg [2:0]          tx_state_d;
  reg                gtx_clk_q;
  reg                gmii_tx_er_q;
  reg [7:0]          gmii_txd_q;
  reg                rx_lpi_q;
  reg                duplex_full_q;
  reg [31:0]         rd_word;
  reg                addr_hit;

  wire [11:0]        async_bundle;
  wire [11:0]        rx_sync;
  wire               rx_dv_s;
  wire               rx_er_s;
  wire [7:0]         rxd_s;
  wire               duplex_pin_s;
  wire               tx_clk_s;
  wire               setup_phase;
  wire               wr_strobe;
  wire               detected_full;
  wire               lpi_start;
  wire               self_exit_due;
  wire               clock_halt;
  wire               protected_clear;
  wire               ctl_write;
  wire               en_write;
  wire               delay_write;
  wire               timer_clear;

  // ==========================================================
  // Input synchronisers
  // Bit order fixes the slices below
  assign async_bundle = {tx_clk_src_i, phy_duplex_indication_i, gmii_rx_dv_i,
                         gmii_rx_er_i, gmii_rxd_i};

  medc_sync #(
    .W (12)
  ) u_rx_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (async_bundle),
    .sync_o    (rx_sync)
  );

  assign tx_clk_s     = rx_sync[11];
  assign duplex_pin_s = rx_sync[10];
  assign rx_dv_s      = rx_sync[9];
  assign rx_er_s      = rx_sync[8];
  assign rxd_s        = rx_sync[7:0];

  // ==========================================================
  // APB decode
  assign setup_phase = psel_i & ~penable_i;
  assign wr_strobe   = psel_i & penable_i & pready_q & pwrite_i & ~pslverr_q;
  assign ctl_write   = wr_strobe & (paddr_i == `MEDC_OFF_CONTROL);
  assign en_write    = wr_strobe & (paddr_i == `MEDC_OFF_ENABLE);
  assign delay_write = wr_strobe & (paddr_i == `MEDC_OFF_DELAY);

  always @* begin
    rd_word  = 32'h0000_0000;
    addr_hit = 1'b1;
    case (paddr_i)
      `MEDC_OFF_CONTROL: begin
        // Reserved positions stay zero
        rd_word[`MEDC_CTL_HALT]  = tx_clock_halt_enable_q;
        rd_word[`MEDC_CTL_EEE]   = energy_saving_enable_q;
        rd_word[`MEDC_CTL_SELFX] = lpi_self_exit_enable_q;
        rd_word[`MEDC_CTL_POL]   = duplex_indication_polarity_q;
        rd_word[`MEDC_CTL_AUTO]  = auto_duplex_q;
        rd_word[`MEDC_CTL_DPX]   = duplex_select_q;
      end
      `MEDC_OFF_ENABLE: begin
        rd_word[`MEDC_EN_RX] = receiver_enable_q;
        rd_word[`MEDC_EN_TX] = transmitter_enable_q;
      end
      `MEDC_OFF_DELAY: begin
        rd_word[DELAY_W-1:0] = lpi_self_exit_delay_q;
      end
      `MEDC_OFF_STATUS: begin
        rd_word[`MEDC_ST_TX_LPI] = tx_state_q[1];
        rd_word[`MEDC_ST_RX_LPI] = rx_lpi_q;
        rd_word[`MEDC_ST_FULL]   = duplex_full_q;
        rd_word[`MEDC_ST_HALTED] = clock_halt;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // Answer one cycle after setup: access phase has pready high
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup_phase;
      pslverr_q <= setup_phase & ~addr_hit;
      if (setup_phase & ~pwrite_i) begin
        prdata_q <= rd_word;
      end else if (~psel_i) begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Control register file
  assign protected_clear = lite_rst_i & ~rst_protect_i;
  assign detected_full   = duplex_indication_polarity_q ? duplex_pin_s : ~duplex_pin_s;

  // Protected fields: only power-on reset or unprotected lite reset
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_clock_halt_enable_q       <= `MEDC_RST_HALT;
      energy_saving_enable_q       <= `MEDC_RST_EEE;
      lpi_self_exit_enable_q       <= `MEDC_RST_SELFX;
      duplex_indication_polarity_q <= `MEDC_RST_POL;
      auto_duplex_q                <= `MEDC_RST_AUTO;
    end else if (protected_clear) begin
      tx_clock_halt_enable_q       <= `MEDC_RST_HALT;
      energy_saving_enable_q       <= `MEDC_RST_EEE;
      lpi_self_exit_enable_q       <= `MEDC_RST_SELFX;
      duplex_indication_polarity_q <= `MEDC_RST_POL;
      auto_duplex_q                <= `MEDC_RST_AUTO;
    end else if (ctl_write) begin
      tx_clock_halt_enable_q       <= pwdata_i[`MEDC_CTL_HALT];
      energy_saving_enable_q       <= pwdata_i[`MEDC_CTL_EEE];
      lpi_self_exit_enable_q       <= pwdata_i[`MEDC_CTL_SELFX];
      duplex_indication_polarity_q <= pwdata_i[`MEDC_CTL_POL];
      auto_duplex_q                <= pwdata_i[`MEDC_CTL_AUTO];
    end
  end

  // Unprotected fields: cleared by any lite reset
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      duplex_select_q       <= `MEDC_RST_DPX;
      transmitter_enable_q  <= 1'b0;
      receiver_enable_q     <= 1'b0;
      lpi_self_exit_delay_q <= `MEDC_RST_DELAY;
    end else if (lite_rst_i) begin
      duplex_select_q       <= `MEDC_RST_DPX;
      transmitter_enable_q  <= 1'b0;
      receiver_enable_q     <= 1'b0;
      lpi_self_exit_delay_q <= `MEDC_RST_DELAY;
    end else begin
      if (auto_duplex_q) begin
        // Detection result wins over a software write
        duplex_select_q <= detected_full;
      end else if (ctl_write) begin
        duplex_select_q <= pwdata_i[`MEDC_CTL_DPX];
      end
      if (en_write) begin
        receiver_enable_q    <= pwdata_i[`MEDC_EN_RX];
        transmitter_enable_q <= pwdata_i[`MEDC_EN_TX];
      end
      if (delay_write) begin
        lpi_self_exit_delay_q <= pwdata_i[DELAY_W-1:0];
      end
    end
  end

  // ==========================================================
  // Transmit LPI sequencing
  assign lpi_start = tx_state_q[0] & energy_saving_enable_q & tx_lpi_request_i;
  // Timer held idle outside LPI
  assign timer_clear = ~tx_state_q[1] & ~lpi_start;

  medc_lpi_timer #(
    .W (DELAY_W)
  ) u_lpi_timer (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .clear_i   (timer_clear),
    .start_i   (lpi_start),
    .delay_i   (lpi_self_exit_delay_q),
    .expired_o (self_exit_due)
  );

  // Transmitter enable deliberately not consulted
  always @* begin
    tx_state_d = tx_state_q;
    case (tx_state_q)
      ST_ACTIVE: begin
        if (lpi_start) begin
          tx_state_d = ST_LPI;
        end
      end
      ST_LPI: begin
        if (~energy_saving_enable_q || ~tx_lpi_request_i) begin
          tx_state_d = ST_ACTIVE;
        end else if (lpi_self_exit_enable_q && self_exit_due) begin
          tx_state_d = ST_EXITED;
        end
      end
      ST_EXITED: begin
        // Stay awake until the request is withdrawn or energy saving is disabled
        if (~tx_lpi_request_i || ~energy_saving_enable_q) begin
          tx_state_d = ST_ACTIVE;
        end
      end
      default: begin
        tx_state_d = ST_ACTIVE;
      end
    endcase
  end

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_state_q <= ST_ACTIVE;
    end else if (lite_rst_i) begin
      tx_state_q <= ST_ACTIVE;
    end else begin
      tx_state_q <= tx_state_d;
    end
  end

  // ==========================================================
  // GMII transmit: LPI code and clock halt
  assign clock_halt = tx_clock_halt_enable_q & tx_state_q[1]
                    & (link_speed_i != `MEDC_SPEED_100);

  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gtx_clk_q    <= 1'b0;
      gmii_tx_er_q <= 1'b0;
      gmii_txd_q   <= `MEDC_IDLE_CODE;
    end else begin
      gtx_clk_q    <= tx_clk_s & ~clock_halt;
      gmii_tx_er_q <= tx_state_q[1];
      gmii_txd_q   <= tx_state_q[1] ? `MEDC_LPI_CODE : `MEDC_IDLE_CODE;
    end
  end

  // ==========================================================
  // Receive LPI decode and duplex result
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_lpi_q      <= 1'b0;
      duplex_full_q <= `MEDC_RST_DPX;
    end else begin
      // Receiver enable deliberately not consulted
      rx_lpi_q <= energy_saving_enable_q & ~rx_dv_s & rx_er_s
                & (rxd_s == `MEDC_LPI_CODE);
      duplex_full_q <= auto_duplex_q ? detected_full : duplex_select_q;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata_o             = prdata_q;
  assign pready_o             = pready_q;
  assign pslverr_o            = pslverr_q;
  assign gtx_clk_o            = gtx_clk_q;
  assign gmii_tx_er_o         = gmii_tx_er_q;
  assign gmii_txd_o           = gmii_txd_q;
  assign tx_lpi_active_o      = gmii_tx_er_q;
  assign rx_lpi_active_o      = rx_lpi_q;
  assign duplex_full_o        = duplex_full_q;
  assign transmitter_enable_o = transmitter_enable_q;
  assign receiver_enable_o    = receiver_enable_q;

endmodule // medc_top

// >>> verification/medc_top_properties.sv
/*
  Port-level checker for medc_top, bound to every instance.
  Assumes registered APB answers and GMII line codes as in the defs header.
*/
`timescale 1ns/100ps
module medc_checker (
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        tx_lpi_request_i,
  input wire logic        gmii_tx_er_o,
  input wire logic [7:0]  gmii_txd_o,
  input wire logic        gmii_rx_dv_i,
  input wire logic        gmii_rx_er_i,
  input wire logic [7:0]  gmii_rxd_i,
  input wire logic        tx_lpi_active_o,
  input wire logic        rx_lpi_active_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  // ============================================================
  // Sequences
  sequence apb_setup;
    psel_i && !penable_i;
  endsequence
  sequence apb_idle;
    !psel_i [*2];
  endsequence

  // ============================================================
  // Properties
  setup_answer_a: assert property (apb_setup |=> pready_o) else $error("no answer after setup");
  ready_single_a: assert property (pready_o |=> !pready_o) else $error("pready longer than one cycle");
  ready_access_a: assert property (pready_o |-> psel_i && penable_i) else $error("pready outside access");
  err_ready_a: assert property (pslverr_o |-> pready_o) else $error("pslverr without pready");
  idle_rdata_a: assert property (apb_idle |-> prdata_o == 32'h0) else $error("read data not zero when idle");
  lpi_code_a: assert property (gmii_txd_o == (gmii_tx_er_o ? 8'h01 : 8'h00)) else $error("bad LPI code");
  lpi_mirror_a: assert property (tx_lpi_active_o == gmii_tx_er_o) else $error("LPI flag differs from line");
  lpi_cause_a: assert property ($rose(gmii_tx_er_o) |-> $past(tx_lpi_request_i, 2))
    else $error("LPI without request");
  rx_decode_a: assert property (rx_lpi_active_o |-> !$past(gmii_rx_dv_i, 3) && $past(gmii_rx_er_i, 3)
    && $past(gmii_rxd_i, 3) == 8'h01) else $error("receive LPI without pattern");
endmodule // medc_checker

bind medc_top medc_checker u_medc_checker (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_lpi_request_i(tx_lpi_request_i),
  .gmii_tx_er_o(gmii_tx_er_o), .gmii_txd_o(gmii_txd_o), .gmii_rx_dv_i(gmii_rx_dv_i),
  .gmii_rx_er_i(gmii_rx_er_i), .gmii_rxd_i(gmii_rxd_i), .tx_lpi_active_o(tx_lpi_active_o),
  .rx_lpi_active_o(rx_lpi_active_o));

// >>> verification/medc_phy_model.sv
/*
  PHY stand-in on GMII: transmit clock source, receive LPI and duplex pin.
  Assumes the bench commands LPI and the duplex level.
*/
`timescale 1ns/100ps
module medc_phy_model (
  input  wire logic       sys_clk_i,
  input  wire logic       lpi_i,
  input  wire logic       dpx_pin_i,
  output logic            tx_clk_src_o,
  output logic            rx_dv_o,
  output logic            rx_er_o,
  output logic [7:0]      rxd_o,
  output logic            duplex_o
);
  // Free-running source, tolerant of a halted forward clock
  initial begin
    tx_clk_src_o = 1'b0;
    forever #160 tx_clk_src_o = ~tx_clk_src_o;
  end
  always @(posedge sys_clk_i) begin
    rx_dv_o <= 1'b0;
    rx_er_o <= lpi_i;
    rxd_o <= lpi_i ? 8'h01 : 8'h00;
    duplex_o <= dpx_pin_i;
  end
endmodule // medc_phy_model

// >>> verification/tb.sv
/*
  Self-checking bench for medc_top: register table, LPI, duplex, lite reset.
  Assumes the PHY model and the bound checker.
*/
`timescale 1ns/100ps
module tb;
  typedef struct packed {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} medc_row_t;
  logic        clk, rst, lite, prot, psel, pen, pwr, req, lpi_cmd, dpx_pin, rd_e, hi;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [1:0]  speed;
  wire  [31:0] prdata;
  wire  [7:0]  txd, rxd;
  wire         pready, pslverr, gtx, txer, rxlpi, full, src, rxdv, rxer, duplex_select, transmitter_enable, receiver_enable, txlpi;
  integer      error_cnt = 0, checks_done = 0, i, n;
  medc_row_t   rows [5];
  logic [2:0]  dtab [4];

  medc_top u_medc_top (.sys_clk_i(clk), .sys_rst_i(rst), .lite_rst_i(lite), .rst_protect_i(prot),
    .paddr_i(paddr), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .link_speed_i(speed), .tx_lpi_request_i(req), .tx_clk_src_i(src),
    .gtx_clk_o(gtx), .gmii_tx_er_o(txer), .gmii_txd_o(txd), .gmii_rx_dv_i(rxdv), .gmii_rx_er_i(rxer),
    .gmii_rxd_i(rxd), .phy_duplex_indication_i(duplex_select), .tx_lpi_active_o(txlpi), .rx_lpi_active_o(rxlpi),
    .duplex_full_o(full), .transmitter_enable_o(transmitter_enable), .receiver_enable_o(receiver_enable));
  medc_phy_model u_medc_phy_model (.sys_clk_i(clk), .lpi_i(lpi_cmd), .dpx_pin_i(dpx_pin),
    .tx_clk_src_o(src), .rx_dv_o(rxdv), .rx_er_o(rxer), .rxd_o(rxd), .duplex_o(duplex_select));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ============================================================
  // Tasks
  task chk(input [31:0] seen, input [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task apb(input [11:0] a, input w, input [31:0] d);
    integer k;
    psel <= 1'b1; pen <= 1'b0; paddr <= a; pwr <= w; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin error_cnt++; results; end
    rd = prdata; rd_e = pslverr;
    psel <= 1'b0; pen <= 1'b0;
    @(posedge clk);
  endtask
  task wait_er(input v);
    n = 0;
    while (txer !== v && n < 40) begin @(posedge clk); n++; end
    if (txer !== v) begin error_cnt++; results; end
  endtask
  task watch(input integer c, input sel);
    hi = 1'b0;
    repeat (c) begin @(posedge clk); hi = hi | (sel ? gtx : txer); end
  endtask

  // ============================================================
  // Sequence
  initial begin
    rst = 1'b1; lite = 1'b0; prot = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; speed = 2'b10; req = 1'b0; lpi_cmd = 1'b0; dpx_pin = 1'b0;
    rows[0] = {12'h100, 32'hffff_efff, 32'h0007_2008, 1'b0};
    rows[1] = {12'h104, 32'hffff_ffff, 32'h0000_0003, 1'b0};
    rows[2] = {12'h108, 32'h0000_0005, 32'h0000_0005, 1'b0};
    rows[3] = {12'h200, 32'hffff_ffff, 32'h0000_0000, 1'b1};
    rows[4] = {12'h10c, 32'hffff_ffff, 32'h0000_0004, 1'b0};
    dtab[0] = 3'b111; dtab[1] = 3'b100; dtab[2] = 3'b001; dtab[3] = 3'b010;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(12'h100, 1'b0, 32'h0); chk(rd, 32'h0000_2000);
    for (i = 0; i < 5; i++) begin
      apb(rows[i].a, 1'b1, rows[i].w); chk(rd_e, rows[i].e);
      apb(rows[i].a, 1'b0, 32'h0); chk(rd, rows[i].r);
      chk(rd_e, rows[i].e);
    end
    chk({transmitter_enable, receiver_enable}, 2'b11);
    // Clock halt with both enables cleared
    apb(12'h100, 1'b1, 32'h0001_2008);
    apb(12'h104, 1'b1, 32'h0);
    chk({transmitter_enable, receiver_enable}, 2'b00);
    apb(12'h100, 1'b1, 32'h0006_2000);
    req <= 1'b1;
    wait_er(1'b1);
    chk(txd, 8'h01);
    chk(txlpi, 1'b1);
    watch(16, 1'b1); chk(hi, 1'b0);
    speed <= 2'b01;
    watch(24, 1'b1); chk(hi, 1'b1);
    req <= 1'b0;
    wait_er(1'b0);
    speed <= 2'b10;
    apb(12'h100, 1'b1, 32'h0004_2000);
    req <= 1'b1;
    watch(10, 1'b0); chk(hi, 1'b0);
    req <= 1'b0;
    // Self-exit with the delay register at five
    apb(12'h100, 1'b1, 32'h0001_2000);
    apb(12'h100, 1'b1, 32'h0003_2000);
    req <= 1'b1;
    wait_er(1'b1);
    n = 0;
    while (txer === 1'b1 && n < 40) begin @(posedge clk); n++; end
    chk(n >= 5 && n <= 10, 1'b1);
    watch(10, 1'b0); chk(hi, 1'b0);
    req <= 1'b0;
    // Receive LPI, receiver disabled
    apb(12'h100, 1'b1, 32'h0001_2000);
    apb(12'h100, 1'b1, 32'h0002_2000);
    lpi_cmd <= 1'b1;
    repeat (6) @(posedge clk);
    chk(rxlpi, 1'b1);
    apb(12'h100, 1'b1, 32'h0000_2000);
    repeat (6) @(posedge clk);
    chk(rxlpi, 1'b0);
    lpi_cmd <= 1'b0;
    // Duplex detection: polarity, pin, expected full
    for (i = 0; i < 4; i++) begin
      apb(12'h100, 1'b1, dtab[i][2] ? 32'h0000_3000 : 32'h0000_1000);
      dpx_pin <= dtab[i][1];
      repeat (6) @(posedge clk);
      chk(full, dtab[i][0]);
      apb(12'h100, 1'b0, 32'h0); chk(rd[3], dtab[i][0]);
    end
    // Detection off first: while on, it overrides the written bit
    apb(12'h100, 1'b1, 32'h0000_2000);
    apb(12'h100, 1'b1, 32'h0000_2008);
    dpx_pin <= 1'b0;
    repeat (6) @(posedge clk);
    chk(full, 1'b1);
    // Lite reset with and without protection
    apb(12'h100, 1'b1, 32'h0007_2000);
    prot <= 1'b1; lite <= 1'b1;
    @(posedge clk);
    lite <= 1'b0;
    @(posedge clk);
    apb(12'h100, 1'b0, 32'h0); chk(rd, 32'h0007_2000);
    apb(12'h108, 1'b0, 32'h0); chk(rd, 32'h0000_0000);
    prot <= 1'b0; lite <= 1'b1;
    @(posedge clk);
    lite <= 1'b0;
    @(posedge clk);
    apb(12'h100, 1'b0, 32'h0); chk(rd, 32'h0000_2000);
    chk({transmitter_enable, receiver_enable}, 2'b00);
    results;
  end
endmodule // tb
